//--- src/dram_refresh_and_parity.sv
// refresh scheduler and byte parity logic of the dram controller
//
// What this block does
// [RQ1] per-bank enable: parity generated writes, checked reads
// [RQ2] odd or even parity from select bit
// [RQ3] internal master bus error only when enabled
// [RQ4] error pin held until bank flag cleared
// [RQ5] no parity for async external masters
// [RQ6] no parity on externally acknowledged cycles
// [RQ7] cas asserted before ras, no row address
// [RQ8] each refresh timer expiry requests one refresh
// [RQ9] refresh bus request at priority level 6
// [RQ10] bus clear asserted while requesting for refresh
// [RQ11] after grant, run refresh cycle on bank
// [RQ12] software scales interval by number of banks
// [RQ13] successive refreshes alternate between banks
// [RQ14] queue seven requests, run them back to back
// [RQ15] refresh runs only while enable bit set
// [RQ16] refresh cycle length three to six clocks
// [RQ17] interval taken from refresh count field
// [RQ18] software does eight reads after enabling bank
// [RQ19] timer reloads; pending count saturates
// [RQ20] reset: no pending refresh, error pin off
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module dram_refresh_and_parity #(
  parameter int BANKS = 2
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire dram_refresh_pkg::acc_s ACC,
  input wire logic [31:0] RD_DATA,
  input wire logic [3:0] PRTY_IN,
  output logic [3:0] PRTY_OUT,
  output logic [3:0] PRTY_OE_N,
  output logic BUS_ERR,
  output logic PARITY_ERROR_PIN_N,
  output logic BUS_REQ,
  output logic [2:0] BUS_REQ_LEVEL,
  output logic BUS_CLEAR_OUT,
  input wire logic BUS_GRANT,
  output dram_refresh_pkg::strobe_s STROBES
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] gmr_r;
  logic [3:0] par_en_r;
  logic [3:0] parity_error_pin_flag_r;
  logic [3:0] parity_error_pin_set;
  logic [2:0] pending_r;
  logic [1:0] bank_r;
  dram_refresh_pkg::rfsh_e state_r;
  logic [15:0] timer_r;
  logic [2:0] step_r;
  logic acc_phase;
  logic wr_hit;
  logic map_hit;
  logic [31:0] rd_mux;

  // field views of the global memory register
  logic [15:0] refresh_interval_count;
  logic [2:0] cyc_len;
  logic refresh_enable_bit;
  logic odd_sel;
  logic parity_bus_error_enable;
  assign refresh_interval_count = gmr_r[dram_refresh_pkg::REFRESH_INTERVAL_COUNT_LSB +: dram_refresh_pkg::REFRESH_INTERVAL_COUNT_W];
  assign cyc_len = {1'b0, gmr_r[dram_refresh_pkg::REFRESH_CYCLE_LENGTH_LSB +:
                   dram_refresh_pkg::REFRESH_CYCLE_LENGTH_W]} + dram_refresh_pkg::REFRESH_CYCLE_LENGTH_BASE;
  assign refresh_enable_bit = gmr_r[dram_refresh_pkg::REFRESH_ENABLE_BIT_BIT];
  assign odd_sel = gmr_r[dram_refresh_pkg::ODD_PARITY_SELECT_BIT];
  assign parity_bus_error_enable = gmr_r[dram_refresh_pkg::PARITY_BUS_ERROR_ENABLE_BIT];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: ready rises the cycle after penable
  assign acc_phase = PSEL & PENABLE & ~PREADY;
  assign map_hit = (PADDR == dram_refresh_pkg::GMR_OFS) |
                   (PADDR == dram_refresh_pkg::PARCFG_OFS) |
                   (PADDR == dram_refresh_pkg::MEMORY_STATUS_REGISTER_OFS) |
                   (PADDR == dram_refresh_pkg::RSTAT_OFS);
  assign wr_hit = PSEL & PENABLE & PREADY & PWRITE;

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      dram_refresh_pkg::GMR_OFS: rd_mux = gmr_r;
      dram_refresh_pkg::PARCFG_OFS: rd_mux = {28'h0, par_en_r};
      dram_refresh_pkg::MEMORY_STATUS_REGISTER_OFS: rd_mux = {28'h0, parity_error_pin_flag_r};
      dram_refresh_pkg::RSTAT_OFS:
        rd_mux = {24'h0, bank_r, state_r, 1'b0, pending_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // answer timing and error for unmapped addresses
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= acc_phase;
      PSLVERR <= acc_phase & ~map_hit;
      PRDATA <= (acc_phase & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // configuration registers, written at the completing edge
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      gmr_r <= dram_refresh_pkg::GMR_RST;
      par_en_r <= dram_refresh_pkg::PARCFG_RST;
    end else if (wr_hit) begin
      if (PADDR == dram_refresh_pkg::GMR_OFS)
        gmr_r <= PWDATA;
      if (PADDR == dram_refresh_pkg::PARCFG_OFS)
        par_en_r <= PWDATA[3:0];
    end
  end

  // ----------------------------------------------------------------
  // parity generation
  // ----------------------------------------------------------------
  logic par_ok_w;
  logic [3:0] gen_par;
  // [RQ5] [RQ6] no parity for async or externally ended cycles
  assign par_ok_w = ACC.valid & par_en_r[ACC.bank] & ~ACC.ext_async &
                    ~ACC.ext_ack;

  // [RQ1] [RQ2] one parity bit per byte, odd or even
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gen
      assign gen_par[gi] = ^ACC.wdata[gi*8 +: 8] ^ odd_sel;
    end
  endgenerate

  // [RQ1] drive parity lines on enabled writes only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PRTY_OUT <= 4'h0;
      PRTY_OE_N <= 4'hF;
    end else begin
      PRTY_OUT <= gen_par;
      PRTY_OE_N <= (par_ok_w & ACC.write) ? 4'h0 : 4'hF;
    end
  end

  // ----------------------------------------------------------------
  // parity check
  // ----------------------------------------------------------------
  // pin inputs through two flops; the read qualifier is delayed alike
  logic [31:0] rd_s1_r;
  logic [31:0] rd_s2_r;
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [1:0] chk_v_r;
  logic [1:0] chk_int_r;
  logic [1:0] chk_bank0_r;
  logic [1:0] chk_bank1_r;
  logic [3:0] bad_byte;
  logic chk_err;
  logic [1:0] chk_bank;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rd_s1_r <= 32'h0000_0000;
      rd_s2_r <= 32'h0000_0000;
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      rd_s1_r <= RD_DATA;
      rd_s2_r <= rd_s1_r;
      pin_s1_r <= PRTY_IN;
      pin_s2_r <= pin_s1_r;
    end
  end

  // [RQ1] check qualifier is delayed two cycles, in step with the data
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      chk_v_r <= 2'h0;
      chk_int_r <= 2'h0;
      chk_bank0_r <= 2'h0;
      chk_bank1_r <= 2'h0;
    end else begin
      chk_v_r <= {chk_v_r[0], par_ok_w & ~ACC.write};
      chk_int_r <= {chk_int_r[0], ACC.internal};
      chk_bank0_r <= ACC.bank;
      chk_bank1_r <= chk_bank0_r;
    end
  end

  // [RQ2] recompute parity of received bytes
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chk
      assign bad_byte[gi] = (^rd_s2_r[gi*8 +: 8] ^ odd_sel) != pin_s2_r[gi];
    end
  endgenerate
  assign chk_err = chk_v_r[1] & (|bad_byte);
  assign chk_bank = chk_bank1_r;
  assign parity_error_pin_set = chk_err ? (4'h1 << chk_bank) : 4'h0;

  // [RQ4] write one to clear; a new error wins over the clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      parity_error_pin_flag_r <= dram_refresh_pkg::MEMORY_STATUS_REGISTER_RST;
    end else if (wr_hit && PADDR == dram_refresh_pkg::MEMORY_STATUS_REGISTER_OFS) begin
      parity_error_pin_flag_r <= (parity_error_pin_flag_r & ~PWDATA[3:0]) | parity_error_pin_set;
    end else begin
      parity_error_pin_flag_r <= parity_error_pin_flag_r | parity_error_pin_set;
    end
  end

  // [RQ4] [RQ20] pin low while any flag stands; [RQ3] bus error pulse
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PARITY_ERROR_PIN_N <= 1'b1;
      BUS_ERR <= 1'b0;
    end else begin
      PARITY_ERROR_PIN_N <= ~(|parity_error_pin_flag_r | chk_err);
      BUS_ERR <= chk_err & chk_int_r[1] & parity_bus_error_enable;
    end
  end

  // ----------------------------------------------------------------
  // refresh timer and request queue
  // ----------------------------------------------------------------
  logic expire;
  logic start;
  // [RQ8] [RQ17] timer counts the programmed interval
  assign expire = refresh_enable_bit && (timer_r == 16'h0000);

  // [RQ19] reload on each expiry
  always_ff @(posedge SYS_CLK) begin
    if (RST)
      timer_r <= 16'h0000;
    else if (!refresh_enable_bit || expire)
      timer_r <= refresh_interval_count;
    else
      timer_r <= timer_r - 16'h0001;
  end

  // [RQ14] [RQ19] [RQ20] queue of up to seven, saturating
  always_ff @(posedge SYS_CLK) begin
    if (RST)
      pending_r <= 3'h0;
    else if (expire && !start && pending_r != dram_refresh_pkg::MAX_PENDING)
      pending_r <= pending_r + 3'h1;
    else if (start && !expire)
      pending_r <= pending_r - 3'h1;
  end

  // ----------------------------------------------------------------
  // refresh sequencer
  // ----------------------------------------------------------------
  logic last_step;
  assign last_step = (step_r == cyc_len - 3'h1);
  // [RQ11] [RQ15] start a cycle once granted and enabled
  assign start = refresh_enable_bit && (pending_r != 3'h0) && BUS_GRANT &&
                 (state_r == dram_refresh_pkg::R_REQ ||
                  (state_r == dram_refresh_pkg::R_CYCLE && last_step));

  // [RQ14] back-to-back cycles while requests remain
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= dram_refresh_pkg::R_IDLE;
      step_r <= 3'h0;
    end else begin
      case (state_r)
        dram_refresh_pkg::R_IDLE: begin
          if (refresh_enable_bit && pending_r != 3'h0)
            state_r <= dram_refresh_pkg::R_REQ;
        end
        dram_refresh_pkg::R_REQ: begin
          step_r <= 3'h0;
          if (start)
            state_r <= dram_refresh_pkg::R_CYCLE;
          else if (!refresh_enable_bit)
            state_r <= dram_refresh_pkg::R_IDLE;
        end
        dram_refresh_pkg::R_CYCLE: begin
          // [RQ16] cycle lasts three to six clocks
          if (!last_step)
            step_r <= step_r + 3'h1;
          else if (start)
            step_r <= 3'h0;
          else
            state_r <= dram_refresh_pkg::R_IDLE;
        end
        default: state_r <= dram_refresh_pkg::R_IDLE;
      endcase
    end
  end

  // [RQ13] next bank after each refresh cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST)
      bank_r <= 2'h0;
    else if (state_r == dram_refresh_pkg::R_CYCLE && last_step)
      bank_r <= (bank_r == 2'(BANKS - 1)) ? 2'h0 : bank_r + 2'h1;
  end

  // [RQ9] [RQ10] request at level 6 with bus clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BUS_REQ <= 1'b0;
      BUS_CLEAR_OUT <= 1'b0;
      BUS_REQ_LEVEL <= 3'h0;
    end else begin
      BUS_REQ <= refresh_enable_bit && (pending_r != 3'h0 ||
                 state_r == dram_refresh_pkg::R_CYCLE);
      BUS_CLEAR_OUT <= refresh_enable_bit && pending_r != 3'h0 &&
                       state_r != dram_refresh_pkg::R_CYCLE;
      BUS_REQ_LEVEL <= dram_refresh_pkg::REFRESH_LEVEL;
    end
  end

  // [RQ7] cas from first clock, ras one later, both off on the last
  logic cas_on;
  logic ras_on;
  assign cas_on = (state_r == dram_refresh_pkg::R_CYCLE) && !last_step;
  assign ras_on = cas_on && step_r != 3'h0;
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      STROBES <= '1;
    end else begin
      STROBES.cas_n <= ~(cas_on ? (4'h1 << bank_r) : 4'h0);
      STROBES.ras_n <= ~(ras_on ? (4'h1 << bank_r) : 4'h0);
    end
  end

endmodule : dram_refresh_and_parity

//--- src/dram_refresh_pkg.sv
// constants and carriers for the dram refresh and parity block
package dram_refresh_pkg;
  // register byte addresses on the apb slave
  localparam logic [11:0] GMR_OFS = 12'h000;
  localparam logic [11:0] PARCFG_OFS = 12'h004;
  localparam logic [11:0] MEMORY_STATUS_REGISTER_OFS = 12'h008;
  localparam logic [11:0] RSTAT_OFS = 12'h00C;
  // global_memory_register fields
  localparam int REFRESH_INTERVAL_COUNT_LSB = 0;
  localparam int REFRESH_INTERVAL_COUNT_W = 16;
  localparam int REFRESH_CYCLE_LENGTH_LSB = 16;
  localparam int REFRESH_CYCLE_LENGTH_W = 2;
  localparam int REFRESH_ENABLE_BIT_BIT = 20;
  localparam int ODD_PARITY_SELECT_BIT = 21;
  localparam int PARITY_BUS_ERROR_ENABLE_BIT = 22;
  // reset values
  localparam logic [31:0] GMR_RST = 32'h0000_0000;
  localparam logic [3:0] PARCFG_RST = 4'h0;
  localparam logic [3:0] MEMORY_STATUS_REGISTER_RST = 4'h0;
  // refresh timing
  localparam logic [2:0] REFRESH_CYCLE_LENGTH_BASE = 3'h3;
  localparam logic [2:0] MAX_PENDING = 3'h7;
  localparam logic [2:0] REFRESH_LEVEL = 3'h6;
  localparam int MAX_BANKS = 4;

  // one data phase of a memory access, from the controller core
  typedef struct packed {
    logic valid;
    logic write;
    logic internal;
    logic ext_async;
    logic ext_ack;
    logic [1:0] bank;
    logic [31:0] wdata;
  } acc_s;

  // row and column strobes, active low, one per bank
  typedef struct packed {
    logic [MAX_BANKS-1:0] ras_n;
    logic [MAX_BANKS-1:0] cas_n;
  } strobe_s;

  typedef enum logic [1:0] {R_IDLE, R_REQ, R_CYCLE} rfsh_e;
endpackage : dram_refresh_pkg

//--- verification/dram_bus_partner.sv
// model of the dram data pins and the other bus master
`timescale 1ns/1ps
module dram_bus_partner (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic BUS_REQ,
  input wire logic BUS_CLEAR_OUT,
  input wire logic stall,
  input wire logic drive,
  input wire logic odd,
  input wire logic [3:0] flip,
  input wire logic [31:0] word,
  output logic BUS_GRANT,
  output logic [31:0] RD_DATA,
  output logic [3:0] PRTY_IN
);
  logic [3:0] par;
  logic held_r;
  // ----------------------------------------
  // data pins and arbitration
  // ----------------------------------------
  // byte parity of the returned word, flip bits corrupt lanes
  always_comb begin
    for (int i = 0; i < 4; i++) par[i] = (^word[8*i +: 8]) ^ odd;
  end
  // released lines show the inverse of the last value
  assign RD_DATA = drive ? word : ~word;
  assign PRTY_IN = drive ? par ^ flip : ~(par ^ flip);
  // other master yields on bus clear unless stalling
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      held_r <= 1'b1;
      BUS_GRANT <= 1'b0;
    end else begin
      if (!BUS_REQ) held_r <= 1'b1;
      else if (BUS_CLEAR_OUT && !stall) held_r <= 1'b0;
      BUS_GRANT <= BUS_REQ && !held_r;
    end
  end
endmodule : dram_bus_partner

//--- verification/dram_refresh_and_parity_tb.sv
// self-checking bench for the dram refresh and parity block
`timescale 1ns/1ps
module dram_refresh_and_parity_tb;
  localparam logic [31:0] WORD = 32'h0103_0701;
  localparam logic [31:0] REFRESH_ENABLE_BIT = 32'h0010_0000;
  logic SYS_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, stall = 1'b1, drive = 1'b0, odd = 1'b0;
  logic seen = 1'b0, cas_q = 1'b1, slverr;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, RD_DATA, rd;
  logic PREADY, PSLVERR, BUS_ERR, PARITY_ERROR_PIN_N, BUS_REQ, BUS_CLEAR_OUT, BUS_GRANT;
  logic [3:0] flip = 4'h0, PRTY_IN, PRTY_OUT, PRTY_OE_N;
  logic [2:0] BUS_REQ_LEVEL;
  dram_refresh_pkg::acc_s ACC = '0;
  dram_refresh_pkg::strobe_s STROBES;
  int errors = 0, checked = 0, falls = 0, base = 0;
  // ----------------------------------------
  // design, partner and clock
  // ----------------------------------------
  dram_refresh_and_parity #(.BANKS(2)) dut (.SYS_CLK(SYS_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ACC(ACC), .RD_DATA(RD_DATA), .PRTY_IN(PRTY_IN), .PRTY_OUT(PRTY_OUT),
    .PRTY_OE_N(PRTY_OE_N), .BUS_ERR(BUS_ERR), .PARITY_ERROR_PIN_N(PARITY_ERROR_PIN_N),
    .BUS_REQ(BUS_REQ), .BUS_REQ_LEVEL(BUS_REQ_LEVEL),
    .BUS_CLEAR_OUT(BUS_CLEAR_OUT), .BUS_GRANT(BUS_GRANT), .STROBES(STROBES));
  dram_bus_partner pt (.SYS_CLK(SYS_CLK), .RST(RST), .BUS_REQ(BUS_REQ),
    .BUS_CLEAR_OUT(BUS_CLEAR_OUT), .stall(stall), .drive(drive), .odd(odd),
    .flip(flip), .word(WORD), .BUS_GRANT(BUS_GRANT), .RD_DATA(RD_DATA),
    .PRTY_IN(PRTY_IN));
  always #12.5 SYS_CLK = ~SYS_CLK;
  // count refresh starts and catch bus error pulses
  always @(posedge SYS_CLK) begin
    cas_q <= &STROBES.cas_n;
    if (cas_q && !(&STROBES.cas_n)) falls <= falls + 1;
  end
  always @(negedge SYS_CLK) seen <= seen | BUS_ERR;
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // ready, read data and error are taken at the rising edge itself
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      errors++;
      finish_test();
    end else begin
      rd = PRDATA;
      slverr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask : apb
  task automatic global_memory_register(input logic [31:0] d);
    apb(1'b1, dram_refresh_pkg::GMR_OFS, d);
  endtask : global_memory_register
  // one memory data phase; f is internal, async, external ack
  task automatic acc_op(input logic w, input logic [1:0] b,
                        input logic [2:0] f, input logic bad);
    @(posedge SYS_CLK);
    ACC <= '{1'b1, w, f[2], f[1], f[0], b, WORD};
    drive <= ~w;
    flip <= {1'b0, bad, 2'b00};
    @(posedge SYS_CLK);
    ACC.valid <= 1'b0;
    drive <= 1'b0;
  endtask : acc_op
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    // registers and error pin after reset
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    chk(32'(PARITY_ERROR_PIN_N), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({slverr, rd[30:0]}, 32'h8000_0000);
    // write parity: enabled, off bank, async, acked, odd
    apb(1'b1, dram_refresh_pkg::PARCFG_OFS, 32'h1);
    for (int k = 0; k < 5; k++) begin
      odd = (k == 4);
      global_memory_register({10'h0, odd, 21'h0});
      acc_op(1'b1, {1'b0, k == 1}, {1'b0, k == 2, k == 3}, 1'b0);
      @(negedge SYS_CLK);
      chk(32'(PRTY_OE_N), (k == 0 || k == 4) ? 32'h0 : 32'hF);
      if (k == 0 || k == 4) chk(32'(PRTY_OUT), 32'(4'hB ^ {4{odd}}));
    end
    odd = 1'b0;
    global_memory_register(32'h0040_0000);
    seen = 1'b0;
    repeat (8) acc_op(1'b0, 2'h0, 3'h4, 1'b0);
    repeat (4) @(posedge SYS_CLK);
    chk({seen, PARITY_ERROR_PIN_N}, 32'h1);
    // read errors: enabled, disabled, async, acked, odd good
    for (int k = 0; k < 5; k++) begin
      odd = (k == 4);
      global_memory_register({9'h0, k != 1, odd, 21'h0});
      seen = 1'b0;
      acc_op(1'b0, 2'h0, (k == 2) ? 3'h2 : (k == 3) ? 3'h5 : 3'h4, k < 4);
      repeat (8) @(posedge SYS_CLK);
      chk({seen, !PARITY_ERROR_PIN_N}, {k == 0, k < 2});
      apb(1'b0, dram_refresh_pkg::MEMORY_STATUS_REGISTER_OFS, 32'h0);
      chk(rd, 32'(k < 2));
      apb(1'b1, dram_refresh_pkg::MEMORY_STATUS_REGISTER_OFS, 32'h1);
      repeat (2) @(negedge SYS_CLK);
      chk(32'(PARITY_ERROR_PIN_N), 32'h1);
    end
    // interval 19 gives ten refreshes in 200 clocks
    stall = 1'b0;
    base = falls;
    global_memory_register(REFRESH_ENABLE_BIT | 32'h0000_0013);
    repeat (200) @(posedge SYS_CLK);
    chk(32'(falls - base), 32'hA);
    // queue saturates at seven, then drains back to back
    for (int f = 0; f < 4; f++) begin
      global_memory_register({14'h0, 2'(f), 16'h0});
      stall = 1'b1;
      global_memory_register(REFRESH_ENABLE_BIT | {14'h0, 2'(f), 16'h0004});
      repeat (60) @(posedge SYS_CLK);
      global_memory_register(REFRESH_ENABLE_BIT | {14'h0, 2'(f), 16'h00FF});
      apb(1'b0, dram_refresh_pkg::RSTAT_OFS, 32'h0);
      chk(32'(rd[2:0]), 32'h7);
      chk({BUS_REQ, BUS_CLEAR_OUT, BUS_REQ_LEVEL}, 32'h1E);
      base = falls;
      stall = 1'b0;
      repeat (60) @(posedge SYS_CLK);
      chk(32'(falls - base), 32'h7);
      apb(1'b0, dram_refresh_pkg::RSTAT_OFS, 32'h0);
      chk(32'(rd[2:0]), 32'h0);
    end
    // no refresh while the enable bit is clear
    global_memory_register(32'h0000_0004);
    base = falls;
    repeat (100) @(posedge SYS_CLK);
    apb(1'b0, dram_refresh_pkg::RSTAT_OFS, 32'h0);
    chk({falls - base, rd[2:0]}, 32'h0);
    finish_test();
  end
endmodule : dram_refresh_and_parity_tb

//--- verification/dram_refresh_monitor.sv
// port checker for the dram refresh and parity block
`timescale 1ns/1ps
module dram_refresh_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire dram_refresh_pkg::acc_s ACC,
  input wire logic [3:0] PRTY_OE_N,
  input wire logic BUS_ERR,
  input wire logic PARITY_ERROR_PIN_N,
  input wire logic BUS_REQ,
  input wire logic [2:0] BUS_REQ_LEVEL,
  input wire logic BUS_CLEAR_OUT,
  input wire logic BUS_GRANT,
  input wire dram_refresh_pkg::strobe_s STROBES
);
  logic clr_wr, gmr_wr, cas_lo, wr_ok, rd_int, last0_r;
  logic [2:0] len_r, low_r;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // decode of flag clears, length writes and qualified accesses
  assign clr_wr = PREADY && PWRITE && PADDR == dram_refresh_pkg::MEMORY_STATUS_REGISTER_OFS;
  assign gmr_wr = PREADY && PWRITE && PADDR == dram_refresh_pkg::GMR_OFS;
  assign cas_lo = !(&STROBES.cas_n);
  assign wr_ok = ACC.valid && ACC.write && !ACC.ext_async && !ACC.ext_ack;
  assign rd_int = ACC.valid && !ACC.write && ACC.internal && !ACC.ext_async
    && !ACC.ext_ack;
  // programmed length, strobe low time and last bank refreshed
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      len_r <= 3'h3;
      low_r <= 3'h0;
      last0_r <= 1'b0;
    end else begin
      if (gmr_wr) len_r <= {1'b0, PWDATA[17:16]} + 3'h3;
      low_r <= cas_lo ? low_r + 3'h1 : 3'h0;
      if ($fell(STROBES.cas_n[0])) last0_r <= 1'b1;
      if ($fell(STROBES.cas_n[1])) last0_r <= 1'b0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_cbr_open;
    !STROBES.cas_n[0] ##1 (!STROBES.cas_n[0] && !STROBES.ras_n[0]);
  endsequence
  sequence s_parity_error_pin_quiet;
    !PARITY_ERROR_PIN_N && !clr_wr && !$past(clr_wr);
  endsequence
  a_cas_before_ras: assert property (
    $fell(STROBES.cas_n[0]) |-> s_cbr_open) else $error("cbr order bad");
  a_no_early_ras: assert property (
    !(|(~STROBES.ras_n & $past(STROBES.ras_n) & $past(STROBES.cas_n))))
    else $error("ras fell without cas");
  a_cycle_len: assert property (
    $rose(&STROBES.cas_n) |-> low_r == len_r - 3'h1)
    else $error("refresh length wrong");
  a_bank_alt: assert property (
    $fell(STROBES.cas_n[0]) || $fell(STROBES.cas_n[1])
    |-> $fell(STROBES.cas_n[0]) != last0_r) else $error("bank repeated");
  a_grant_first: assert property (
    $rose(cas_lo) |-> $past(BUS_GRANT)) else $error("cycle without grant");
  a_req_level: assert property (
    BUS_REQ |-> BUS_REQ_LEVEL == dram_refresh_pkg::REFRESH_LEVEL)
    else $error("request level wrong");
  a_clear_in_req: assert property (
    BUS_CLEAR_OUT |-> BUS_REQ) else $error("bus clear without request");
  a_oe_cause: assert property (
    PRTY_OE_N != 4'hF |-> $past(wr_ok)) else $error("parity driven wrongly");
  a_err_cause: assert property (
    BUS_ERR |-> $past(rd_int, 3) && !PARITY_ERROR_PIN_N) else $error("bus error cause");
  a_parity_error_pin_hold: assert property (
    s_parity_error_pin_quiet |=> !PARITY_ERROR_PIN_N) else $error("error pin released early");
endmodule : dram_refresh_monitor

bind dram_refresh_and_parity dram_refresh_monitor mon (.SYS_CLK(SYS_CLK),
  .RST(RST), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .ACC(ACC), .PRTY_OE_N(PRTY_OE_N), .BUS_ERR(BUS_ERR),
  .PARITY_ERROR_PIN_N(PARITY_ERROR_PIN_N), .BUS_REQ(BUS_REQ), .BUS_REQ_LEVEL(BUS_REQ_LEVEL),
  .BUS_CLEAR_OUT(BUS_CLEAR_OUT), .BUS_GRANT(BUS_GRANT), .STROBES(STROBES));
